// ===== design/cmic_pkg.sv
package cmic_pkg;

  // tri-level pin codes as seen by the level sensor in front of this block
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_OPEN = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;

  // clock and time base; every duration scales with the clock rate
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned MS_CYCLES   = CLK_HZ / MS_PER_S;
  localparam int unsigned TEST_S      = 1;
  localparam int unsigned TEST_MS     = TEST_S * MS_PER_S;
  localparam int unsigned FLASH_S     = 1;
  localparam int unsigned FLASH_HALF  = FLASH_S * MS_PER_S / 2;
  localparam int unsigned MR_HOLD_MS  = 700;
  localparam int unsigned SEC_PER_HR  = 3600;
  localparam int unsigned TEN_HOUR_HR = 10;
  localparam logic [15:0] TEN_HOUR_S  = 16'(TEN_HOUR_HR * SEC_PER_HR);
  localparam logic [15:0] COND_S      = TEN_HOUR_S;

  // ten-hour mode cutoffs in seconds, indexed by charge rate 0 (4C) .. 8 (C/4)
  localparam logic [15:0] FAST_CUT_S [9] = '{16'h0438, 16'h0870, 16'h0ca8, 16'h10e0,
    16'h1950, 16'h21c0, 16'h3138, 16'h3840, 16'h40b0};
  localparam logic [15:0] MAINT_CUT_S [9] = '{16'h8868, 16'h8430, 16'h7ff8, 16'h7bc0,
    16'h7350, 16'h6ae0, 16'h5b68, 16'h5460, 16'h4bf0};

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TIMER  = 8'h08;
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned ST_STATE_LSB     = 0;
  localparam int unsigned ST_MODE_LSB      = 4;
  localparam int unsigned ST_RATE_LSB      = 8;
  localparam int unsigned ST_LAMP_LSB      = 12;
  localparam int unsigned TM_STAGE_LSB     = 16;

  typedef enum logic [2:0] {
    MD_FAST, MD_TEST, MD_DIRECT, MD_DISCH_ONLY, MD_DISCH_CHG, MD_COND, MD_TEN
  } cmic_mode_t;

  typedef enum logic [3:0] {
    ST_LATCH, ST_TEST, ST_POLL, ST_DISCH, ST_FAST, ST_TOPPING,
    ST_MAINT, ST_COND, ST_DIRECT, ST_FAULT, ST_OFF
  } cmic_state_t;

endpackage

// ===== design/cmic_tick_div.sv
`timescale 1ns/1ps
module cmic_tick_div #(
  parameter int unsigned DIV = 1000
) (
  input  wire logic ref_clk_in,   // system clock
  input  wire logic rst_n_in,     // sync reset, active low
  input  wire logic clear_in,     // restart the count
  input  wire logic en_in,        // count enable
  output logic      tick_out      // one-cycle pulse every DIV enables
);
  logic [15:0] cnt_q;

  // modulo counter; clear keeps time aligned to the restart
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || clear_in)
    begin
      cnt_q <= 16'h0000;
    end
    else if (en_in)
    begin
      cnt_q <= (cnt_q == 16'(DIV - 1)) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end

  assign tick_out = en_in && (cnt_q == 16'(DIV - 1));
endmodule // cmic_tick_div

// ===== design/cmic_charge_ctrl.sv
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module cmic_charge_ctrl #(
  parameter int unsigned MS_CYCLES = cmic_pkg::MS_CYCLES
) (
  input  wire logic        ref_clk_in,              // 20 MHz system clock
  input  wire logic        rst_n_in,                // sync reset, active low
  input  wire logic        psel_in,                 // apb select
  input  wire logic        penable_in,              // apb access phase
  input  wire logic        pwrite_in,               // apb write
  input  wire logic [7:0]  paddr_in,                // apb byte address
  input  wire logic [31:0] pwdata_in,               // apb write data
  output logic [31:0]      prdata_out,              // apb read data
  output logic             pready_out,              // apb ready
  output logic             pslverr_out,             // apb error, unmapped
  input  wire logic [1:0]  aux_mode_select_a_in,    // tri-level code
  input  wire logic [1:0]  aux_mode_select_b_in,    // tri-level code
  input  wire logic [1:0]  rate_select_a_in,        // tri-level code
  input  wire logic [1:0]  rate_select_b_in,        // tri-level code
  input  wire logic        master_reset_n_in,       // master reset pin
  input  wire logic        battery_present_in,      // from battery sensing
  input  wire logic        fault_in,                // battery fault seen
  input  wire logic        fast_term_in,            // slope termination
  input  wire logic        topping_done_in,         // topping stage over
  input  wire logic        discharge_done_in,       // 1 V/cell reached
  input  wire logic        charge_pulse_in,         // pulse engine: current on
  input  wire logic        discharge_pulse_in,      // pulse engine: load on
  output logic             charge_source_on_out,    // current source enable
  output logic             discharge_load_on_out,   // discharge load enable
  input  wire logic        fast_charge_lamp_n_in,   // lamp pin level
  output logic             fast_charge_lamp_n_out,  // lamp pin drive value
  output logic             fast_charge_lamp_n_oe_out, // high: pulling low
  input  wire logic        maintenance_lamp_n_in,   // lamp pin level
  output logic             maintenance_lamp_n_out,  // lamp pin drive value
  output logic             maintenance_lamp_n_oe_out, // high: pulling low
  input  wire logic        polling_lamp_n_in,       // lamp pin level
  output logic             polling_lamp_n_out,      // lamp pin drive value
  output logic             polling_lamp_n_oe_out    // high: pulling low
);
  cmic_pkg::cmic_state_t state_q;
  cmic_pkg::cmic_state_t state_d;
  cmic_pkg::cmic_mode_t  mode_q;
  cmic_pkg::cmic_mode_t  mode_now;
  logic [3:0]  rate_q;
  logic [3:0]  rate_now;
  logic        restart;
  logic        mr_hold_q;
  logic [9:0]  mr_ms_q;
  logic        sw_restart_q;
  logic        ms_tick;
  logic        s_tick;
  logic [15:0] session_s_q;
  logic [15:0] stage_s_q;
  logic [15:0] post_fast_s_q;
  logic [9:0]  stage_ms_q;
  logic [9:0]  flash_ms_q;
  logic        flash_q;
  logic        charging;
  logic        apb_wr;
  logic        apb_setup;
  logic        addr_ok;

  // one ms enable from the clock, seconds from ms
  cmic_tick_div #(.DIV(MS_CYCLES)) u_ms_div (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (restart),
    .en_in      (1'b1),
    .tick_out   (ms_tick)
  );

  cmic_tick_div #(.DIV(cmic_pkg::MS_PER_S)) u_s_div (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (restart),
    .en_in      (ms_tick),
    .tick_out   (s_tick)
  );

  // pin low counted in ms; shorter pulses are glitches, not resets
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || master_reset_n_in)
    begin
      mr_ms_q <= 10'h000;
    end
    else if (ms_tick && (mr_ms_q <= 10'(cmic_pkg::MR_HOLD_MS)))
    begin
      mr_ms_q <= mr_ms_q + 10'h001;
    end
  end

  // held in reset while the pin stays low past the filter
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      mr_hold_q <= 1'b0;
    end
    else
    begin
      mr_hold_q <= !master_reset_n_in && (mr_ms_q > 10'(cmic_pkg::MR_HOLD_MS));
    end
  end

  assign restart = mr_hold_q || sw_restart_q;

  // tri-level selection decode
  always_comb
  begin
    mode_now = cmic_pkg::MD_FAST;
    // open/open and unlisted pairs fall back to fast charge
    case ({aux_mode_select_a_in, aux_mode_select_b_in})
      {cmic_pkg::TRI_LOW,  cmic_pkg::TRI_LOW}:  mode_now = cmic_pkg::MD_TEST;
      {cmic_pkg::TRI_LOW,  cmic_pkg::TRI_HIGH}: mode_now = cmic_pkg::MD_DIRECT;
      {cmic_pkg::TRI_OPEN, cmic_pkg::TRI_LOW}:  mode_now = cmic_pkg::MD_DISCH_ONLY;
      {cmic_pkg::TRI_HIGH, cmic_pkg::TRI_LOW}:  mode_now = cmic_pkg::MD_DISCH_CHG;
      {cmic_pkg::TRI_HIGH, cmic_pkg::TRI_OPEN}: mode_now = cmic_pkg::MD_COND;
      {cmic_pkg::TRI_HIGH, cmic_pkg::TRI_HIGH}: mode_now = cmic_pkg::MD_TEN;
      default:                                  mode_now = cmic_pkg::MD_FAST;
    endcase
    rate_now = 4'h7;
    // each strap pair picks one of nine rates
    case ({rate_select_a_in, rate_select_b_in})
      {cmic_pkg::TRI_LOW,  cmic_pkg::TRI_LOW}:  rate_now = 4'h0;
      {cmic_pkg::TRI_LOW,  cmic_pkg::TRI_HIGH}: rate_now = 4'h1;
      {cmic_pkg::TRI_LOW,  cmic_pkg::TRI_OPEN}: rate_now = 4'h2;
      {cmic_pkg::TRI_HIGH, cmic_pkg::TRI_LOW}:  rate_now = 4'h3;
      {cmic_pkg::TRI_HIGH, cmic_pkg::TRI_OPEN}: rate_now = 4'h4;
      {cmic_pkg::TRI_HIGH, cmic_pkg::TRI_HIGH}: rate_now = 4'h5;
      {cmic_pkg::TRI_OPEN, cmic_pkg::TRI_LOW}:  rate_now = 4'h6;
      {cmic_pkg::TRI_OPEN, cmic_pkg::TRI_HIGH}: rate_now = 4'h8;
      default:                                  rate_now = 4'h7;
    endcase
  end

  // captured once in the latch state, then frozen
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      mode_q <= cmic_pkg::MD_FAST;
      rate_q <= 4'h7;
    end
    else if (state_q == cmic_pkg::ST_LATCH && !restart)
    begin
      mode_q <= mode_now;
      rate_q <= rate_now;
    end
  end

  assign charging = (state_q == cmic_pkg::ST_FAST) || (state_q == cmic_pkg::ST_TOPPING) ||
                    (state_q == cmic_pkg::ST_MAINT) || (state_q == cmic_pkg::ST_COND) ||
                    (state_q == cmic_pkg::ST_DIRECT);

  // sequence of charge stages
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      cmic_pkg::ST_LATCH:
      begin
        state_d = (mode_now == cmic_pkg::MD_TEST) ? cmic_pkg::ST_TEST : cmic_pkg::ST_POLL;
      end
      cmic_pkg::ST_TEST:
      begin
        // test ends in a dead state
        if (ms_tick && stage_ms_q == 10'(cmic_pkg::TEST_MS - 1))
          state_d = cmic_pkg::ST_OFF;
      end
      cmic_pkg::ST_POLL:
      begin
        if (battery_present_in)
        begin
          case (mode_q)
            cmic_pkg::MD_DISCH_ONLY, cmic_pkg::MD_DISCH_CHG: state_d = cmic_pkg::ST_DISCH;
            cmic_pkg::MD_DIRECT:                             state_d = cmic_pkg::ST_DIRECT;
            cmic_pkg::MD_COND:                               state_d = cmic_pkg::ST_COND;
            default:                                         state_d = cmic_pkg::ST_FAST;
          endcase
        end
      end
      cmic_pkg::ST_DISCH:
      begin
        if (discharge_done_in)
          state_d = (mode_q == cmic_pkg::MD_DISCH_CHG) ? cmic_pkg::ST_FAST : cmic_pkg::ST_OFF;
      end
      cmic_pkg::ST_FAST:
      begin
        // rate-specific fast cutoff in ten-hour mode
        if (fast_term_in || (mode_q == cmic_pkg::MD_TEN &&
            stage_s_q >= cmic_pkg::FAST_CUT_S[rate_q]))
          state_d = cmic_pkg::ST_TOPPING;
      end
      cmic_pkg::ST_TOPPING:
      begin
        if (topping_done_in)
          state_d = cmic_pkg::ST_MAINT;
      end
      cmic_pkg::ST_COND:
      begin
        if (stage_s_q >= cmic_pkg::COND_S)
          state_d = cmic_pkg::ST_MAINT;
      end
      default:
      begin
        state_d = state_q;
      end
    endcase
    // maintenance cutoff after fast end in ten-hour mode
    if (mode_q == cmic_pkg::MD_TEN && (state_q == cmic_pkg::ST_TOPPING ||
        state_q == cmic_pkg::ST_MAINT) && post_fast_s_q >= cmic_pkg::MAINT_CUT_S[rate_q])
      state_d = cmic_pkg::ST_OFF;
    // whole session cut at ten hours from reset in ten-hour mode
    if (mode_q == cmic_pkg::MD_TEN && session_s_q >= cmic_pkg::TEN_HOUR_S &&
        state_q != cmic_pkg::ST_LATCH)
      state_d = cmic_pkg::ST_OFF;
    // removal while charging returns to polling
    if (charging && !battery_present_in)
      state_d = cmic_pkg::ST_POLL;
    // fault parks the block with the polling lamp lit
    if ((charging || state_q == cmic_pkg::ST_POLL) && fault_in)
      state_d = cmic_pkg::ST_FAULT;
  end

  // state register; restart wins over everything
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || restart)
      state_q <= cmic_pkg::ST_LATCH;
    else
      state_q <= state_d;
  end

  // session and stage timers; the second counts saturate, stage_ms_q wraps
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || restart || state_q == cmic_pkg::ST_LATCH)
    begin
      session_s_q   <= 16'h0000;
      stage_s_q     <= 16'h0000;
      post_fast_s_q <= 16'h0000;
      stage_ms_q    <= 10'h000;
    end
    else
    begin
      if (s_tick && session_s_q != 16'hffff)
        session_s_q <= session_s_q + 16'h0001;
      if (state_d != state_q)
        stage_s_q <= 16'h0000;
      else if (s_tick && stage_s_q != 16'hffff)
        stage_s_q <= stage_s_q + 16'h0001;
      if (state_q == cmic_pkg::ST_FAST || state_q == cmic_pkg::ST_POLL)
        post_fast_s_q <= 16'h0000;
      else if (s_tick && post_fast_s_q != 16'hffff)
        post_fast_s_q <= post_fast_s_q + 16'h0001;
      if (state_d != state_q)
        stage_ms_q <= 10'h000;
      else if (ms_tick)
        stage_ms_q <= stage_ms_q + 10'h001;
    end
  end

  // half-second toggle gives a one second flash
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || state_q != cmic_pkg::ST_DISCH)
    begin
      flash_ms_q <= 10'h000;
      flash_q    <= 1'b1;
    end
    else if (ms_tick)
    begin
      if (flash_ms_q == 10'(cmic_pkg::FLASH_HALF - 1))
      begin
        flash_ms_q <= 10'h000;
        flash_q    <= !flash_q;
      end
      else
      begin
        flash_ms_q <= flash_ms_q + 10'h001;
      end
    end
  end

  // registered pin drive; lamps only ever pull low, never drive high
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || restart)
    begin
      charge_source_on_out      <= 1'b0;
      discharge_load_on_out     <= 1'b0;
      fast_charge_lamp_n_oe_out <= 1'b0;
      maintenance_lamp_n_oe_out <= 1'b0;
      polling_lamp_n_oe_out     <= 1'b0;
    end
    else
    begin
      // test lights everything; current is only on or off
      charge_source_on_out <= (state_q == cmic_pkg::ST_TEST) ||
                              ((charging || state_q == cmic_pkg::ST_POLL) && charge_pulse_in);
      // load enable from the discharge pulse engine
      discharge_load_on_out <= (state_q == cmic_pkg::ST_TEST) ||
                               (state_q == cmic_pkg::ST_DISCH && discharge_pulse_in);
      // soft start and fast share the fast state, topping drops it
      fast_charge_lamp_n_oe_out <= (state_q == cmic_pkg::ST_TEST) ||
                                   (state_q == cmic_pkg::ST_FAST);
      // steady in maintenance-type stages, flashing in discharge
      maintenance_lamp_n_oe_out <= (state_q == cmic_pkg::ST_TEST) || (charging &&
                                   state_q != cmic_pkg::ST_FAST) ||
                                   (state_q == cmic_pkg::ST_DISCH && flash_q);
      // polling lamp while probing or faulted
      polling_lamp_n_oe_out <= (state_q == cmic_pkg::ST_TEST) ||
                               (state_q == cmic_pkg::ST_POLL) ||
                               (state_q == cmic_pkg::ST_FAULT);
    end
  end

  assign fast_charge_lamp_n_out = 1'b0;
  assign maintenance_lamp_n_out = 1'b0;
  assign polling_lamp_n_out     = 1'b0;

  // apb: zero-wait slave, read data captured in the setup cycle
  assign apb_setup  = psel_in && !penable_in;
  assign apb_wr     = psel_in && penable_in && pwrite_in;
  assign pready_out = 1'b1;
  assign addr_ok    = (paddr_in == cmic_pkg::REG_CTRL) || (paddr_in == cmic_pkg::REG_STATUS) ||
                      (paddr_in == cmic_pkg::REG_TIMER);

  // software restart behaves like a master reset for one cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      sw_restart_q <= 1'b0;
    else
      sw_restart_q <= apb_wr && (paddr_in == cmic_pkg::REG_CTRL) &&
                      pwdata_in[cmic_pkg::CTRL_RESTART_BIT];
  end

  // read mux and error flag, held through the access phase
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
    else if (apb_setup)
    begin
      pslverr_out <= !addr_ok;
      prdata_out  <= 32'h0000_0000;
      if (paddr_in == cmic_pkg::REG_STATUS)
      begin
        prdata_out[cmic_pkg::ST_STATE_LSB +: 4] <= state_q;
        prdata_out[cmic_pkg::ST_MODE_LSB +: 3]  <= mode_q;
        prdata_out[cmic_pkg::ST_RATE_LSB +: 4]  <= rate_q;
        prdata_out[cmic_pkg::ST_LAMP_LSB +: 3]  <= {polling_lamp_n_in, maintenance_lamp_n_in,
                                                    fast_charge_lamp_n_in};
      end
      else if (paddr_in == cmic_pkg::REG_TIMER)
      begin
        prdata_out[15:0]                         <= session_s_q;
        prdata_out[cmic_pkg::TM_STAGE_LSB +: 16] <= stage_s_q;
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence test_run_s;
    (state_q == cmic_pkg::ST_TEST) && !restart;
  endsequence

  test_all_on_a: assert property (test_run_s |=> charge_source_on_out &&
    discharge_load_on_out && fast_charge_lamp_n_oe_out && maintenance_lamp_n_oe_out &&
    polling_lamp_n_oe_out) else $error("test outputs not all on");
  test_shutdown_a: assert property (test_run_s ##0 (state_d == cmic_pkg::ST_OFF)
    |=> (state_q == cmic_pkg::ST_OFF)) else $error("test did not shut down");
  off_holds_a: assert property ((state_q == cmic_pkg::ST_OFF) && !restart
    |=> (state_q == cmic_pkg::ST_OFF) ##1 !charge_source_on_out) else $error("off left");
  test_entry_a: assert property ((state_q == cmic_pkg::ST_LATCH) && !restart &&
    (mode_now == cmic_pkg::MD_TEST) |=> (state_q == cmic_pkg::ST_TEST))
    else $error("test mode not entered");
  ten_select_a: assert property ((state_q == cmic_pkg::ST_LATCH) && !restart &&
    (mode_now == cmic_pkg::MD_TEN) |=> (mode_q == cmic_pkg::MD_TEN)) else $error("no ten mode");
  mode_frozen_a: assert property ((state_q != cmic_pkg::ST_LATCH)
    |=> $stable(mode_q) && $stable(rate_q)) else $error("selection changed");
  fast_release_a: assert property ($rose(state_q == cmic_pkg::ST_TOPPING) && !restart
    |=> !fast_charge_lamp_n_oe_out) else $error("fast lamp not released");
  poll_lamp_a: assert property ((state_q == cmic_pkg::ST_POLL) && !restart
    |=> polling_lamp_n_oe_out && !fast_charge_lamp_n_oe_out) else $error("poll lamp wrong");
  cond_removal_a: assert property ((state_q == cmic_pkg::ST_COND) && !battery_present_in &&
    !fault_in && !restart |=> (state_q == cmic_pkg::ST_POLL)) else $error("no return to poll");
  session_limit_a: assert property ((mode_q == cmic_pkg::MD_TEN) && charging &&
    battery_present_in && !fault_in && !restart && (session_s_q >= cmic_pkg::TEN_HOUR_S)
    |=> (state_q == cmic_pkg::ST_OFF)) else $error("ten hour limit missed");
  cond_lamp_a: assert property ((state_q == cmic_pkg::ST_COND) && !restart
    |=> maintenance_lamp_n_oe_out) else $error("cond lamp off");
endmodule // cmic_charge_ctrl

// ===== bench/cmic_lamp_model.sv
`timescale 1ns/1ps
module cmic_lamp_model (
  input  wire logic [2:0] oe_in,          // {poll,maint,fast} pulling low
  input  wire logic [2:0] drv_in,         // drive values while pulling
  input  wire logic       chg_en_in,      // current source enable
  output logic [2:0]      pin_out,        // lamp line levels
  output logic            current_on_out  // source delivering current
);
  // open-drain lamp lines
  // a released line is pulled up through its lamp, never left at the last value
  assign pin_out = (oe_in & drv_in) | ~oe_in;
  assign current_on_out = chg_en_in;
endmodule // cmic_lamp_model

// ===== bench/cmic_charge_ctrl_tb_top.sv
`timescale 1ns/1ps
module cmic_charge_ctrl_tb_top;
  localparam logic [1:0] lo = cmic_pkg::TRI_LOW;
  localparam logic [1:0] op = cmic_pkg::TRI_OPEN;
  localparam logic [1:0] hi = cmic_pkg::TRI_HIGH;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, dload, cur, charge_source_on;
  logic [1:0]  aux_a = lo, aux_b = lo, rate_a = lo, rate_b = lo;
  logic        mr_n = 1'b1, batt = 1'b0, fault = 1'b0, fterm = 1'b0, tdone = 1'b0;
  logic        ddone = 1'b0, cpulse = 1'b0, dpulse = 1'b0;
  logic [2:0]  oe, drv, pin;
  logic [3:0]  rcode [9] = '{4'h0, 4'h2, 4'h1, 4'h8, 4'h9, 4'ha, 4'h4, 4'h5, 4'h6};
  int          mismatches = 0, checked = 0;

  // bench clock, 50 ns period
  always #25 clk = ~clk;

  cmic_charge_ctrl #(.MS_CYCLES(4)) u_cmic_charge_ctrl (
    .ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .aux_mode_select_a_in(aux_a),
    .aux_mode_select_b_in(aux_b), .rate_select_a_in(rate_a), .rate_select_b_in(rate_b),
    .master_reset_n_in(mr_n), .battery_present_in(batt), .fault_in(fault),
    .fast_term_in(fterm), .topping_done_in(tdone), .discharge_done_in(ddone),
    .charge_pulse_in(cpulse), .discharge_pulse_in(dpulse), .charge_source_on_out(charge_source_on),
    .discharge_load_on_out(dload), .fast_charge_lamp_n_in(pin[0]),
    .fast_charge_lamp_n_out(drv[0]), .fast_charge_lamp_n_oe_out(oe[0]),
    .maintenance_lamp_n_in(pin[1]), .maintenance_lamp_n_out(drv[1]),
    .maintenance_lamp_n_oe_out(oe[1]), .polling_lamp_n_in(pin[2]),
    .polling_lamp_n_out(drv[2]), .polling_lamp_n_oe_out(oe[2]));

  cmic_lamp_model u_cmic_lamp_model (.oe_in(oe), .drv_in(drv), .chg_en_in(charge_source_on),
    .pin_out(pin), .current_on_out(cur));

  // compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // {current, load, poll, maint, fast} at the pins
  task pins(input logic [4:0] exp);
    @(posedge clk);
    chk("pins", {27'h0, cur, dload, pin}, {27'h0, exp});
  endtask

  task stat(input logic [3:0] s, input logic [2:0] m);
    apb(1'b0, cmic_pkg::REG_STATUS, 32'h0);
    chk("mode_state", {25'h0, rd[6:4], rd[3:0]}, {25'h0, m, s});
  endtask

  // straps only count after a restart
  task straps(input logic [1:0] a, input logic [1:0] b);
    aux_a <= a; aux_b <= b;
    apb(1'b1, cmic_pkg::REG_CTRL, 32'h1);
    wait_n(6);
  endtask

  task print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog, run needs about 11k cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict;
  end

  initial
  begin
    wait_n(20);
    rst_n <= 1'b1;
    wait_n(6);
    stat(cmic_pkg::ST_TEST, cmic_pkg::MD_TEST);
    pins(5'b11000);
    apb(1'b0, cmic_pkg::REG_CTRL, 32'h0);
    chk("ctrl_read", rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    wait_n(4020);
    pins(5'b00111);
    aux_a <= op; aux_b <= op;
    wait_n(8);
    stat(cmic_pkg::ST_OFF, cmic_pkg::MD_TEST);
    cpulse <= 1'b1;
    straps(op, op);
    stat(cmic_pkg::ST_POLL, cmic_pkg::MD_FAST);
    pins(5'b10011);
    batt <= 1'b1;
    wait_n(4);
    pins(5'b10110);
    cpulse <= 1'b0; fterm <= 1'b1;
    wait_n(4);
    fterm <= 1'b0;
    pins(5'b00101);
    fault <= 1'b1;
    wait_n(4);
    fault <= 1'b0;
    pins(5'b00011);
    // every rate strap pair, ten-hour mode
    foreach (rcode[i])
    begin
      rate_a <= rcode[i][3:2]; rate_b <= rcode[i][1:0];
      straps(hi, hi);
      stat(cmic_pkg::ST_FAST, cmic_pkg::MD_TEN);
      chk("rate", {28'h0, rd[11:8]}, i);
    end
    // master reset pin held past 700 ms ticks
    batt <= 1'b0; aux_a <= hi; aux_b <= op; mr_n <= 1'b0;
    wait_n(2900);
    pins(5'b00111);
    mr_n <= 1'b1;
    wait_n(6);
    stat(cmic_pkg::ST_POLL, cmic_pkg::MD_COND);
    batt <= 1'b1;
    wait_n(4);
    pins(5'b00101);
    batt <= 1'b0;
    wait_n(4);
    stat(cmic_pkg::ST_POLL, cmic_pkg::MD_COND);
    batt <= 1'b1; dpulse <= 1'b1;
    straps(hi, lo);
    wait_n(1000);
    pins(5'b01101);
    wait_n(2000);
    pins(5'b01111);
    ddone <= 1'b1;
    wait_n(4);
    stat(cmic_pkg::ST_FAST, cmic_pkg::MD_DISCH_CHG);
    // one second is 1000 ms ticks of MS_CYCLES clocks
    wait_n(1000);
    apb(1'b0, cmic_pkg::REG_TIMER, 32'h0);
    chk("timer", rd, 32'h0001_0001);
    ddone <= 1'b0; cpulse <= 1'b1;
    straps(lo, hi);
    stat(cmic_pkg::ST_DIRECT, cmic_pkg::MD_DIRECT);
    pins(5'b10101);
    straps(op, lo);
    pins(5'b01101);
    ddone <= 1'b1;
    wait_n(4);
    stat(cmic_pkg::ST_OFF, cmic_pkg::MD_DISCH_ONLY);
    print_verdict;
  end
endmodule // cmic_charge_ctrl_tb_top
